// ===== src/spu_core.sv
// Stack pointer unit: pointer pair, stack sequencer and APB registers.
`timescale 1ns/10ps
module spu_core (
	// Clock and reset.
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	// APB slave.
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Stack operation request from the sequencer.
	input  wire logic        op_valid_i,
	input  wire logic [2:0]  op_code_i,
	input  wire logic        op_down_i,
	input  wire logic        op_ext_i,
	input  wire logic [15:0] usr_ptr_i,
	input  wire logic [7:0]  push_data_i,
	input  wire logic [15:0] pc_i,
	input  wire logic [7:0]  flags_i,
	// Stack operation answer.
	output logic             op_busy_o,
	output logic             op_done_o,
	output logic [7:0]       pop_data_o,
	output logic [15:0]      pc_o,
	output logic [7:0]       flags_o,
	output logic [15:0]      usr_ptr_o,
	// External data memory port.
	output logic [15:0]      ext_addr_o,
	output logic [7:0]       ext_wdata_o,
	output logic             ext_wr_o,
	output logic             ext_rd_o,
	input  wire logic [7:0]  ext_rdata_i,
	input  wire logic        ext_ack_i
);

	// ==========================================================
	// Declarations.
	spu_pkg::spu_state_type state;
	logic [7:0]  stack_pointer_high;
	logic [7:0]  stack_pointer_low;
	logic [7:0]  memory_timing_control;
	logic [15:0] work_ptr;
	logic [7:0]  push_buf [3];
	logic [23:0] pop_shift;
	logic [1:0]  byte_cnt;
	logic [1:0]  byte_idx;
	logic        is_pop;
	logic        is_user;
	logic        use_ext;
	logic        step_down;
	logic [2:0]  cur_op;
	logic        apb_access;
	logic        apb_commit;
	logic        op_start;
	logic        last_byte;
	logic        rf_we;
	logic [7:0]  rf_rdata;
	logic        stack_internal;
	logic        user_op;
	logic        pop_op;

	// ==========================================================
	// Decode of requests.

	// Ops wait only during an APB access phase, so a pointer write can still
	// land mid-op and be overwritten by the ST_DONE commit of a non-user op.
	assign apb_access = psel_i & penable_i & ~pready_o;
	assign apb_commit = psel_i & penable_i & pready_o;
	assign op_start   = op_valid_i & (state == spu_pkg::ST_IDLE) &
		~(psel_i & penable_i);
	assign last_byte  = (byte_idx == (byte_cnt - 2'h1));
	assign user_op    = (op_code_i == spu_pkg::OP_UPUSH) |
		(op_code_i == spu_pkg::OP_UPOP);
	assign pop_op     = (op_code_i == spu_pkg::OP_POP) |
		(op_code_i == spu_pkg::OP_RET) |
		(op_code_i == spu_pkg::OP_INTERRUPT_RETURN) |
		(op_code_i == spu_pkg::OP_UPOP);

	// Stack location chosen by the timing control bit; set means the
	// internal register file.
	assign stack_internal =
		memory_timing_control[spu_pkg::MTC_STACK_INT_BIT];

	// Internal writes happen in the put state when the stack is inside.
	assign rf_we = (state == spu_pkg::ST_PUSH_PUT) & ~use_ext;

	// ==========================================================
	// Internal stack storage, addressed by the low pointer byte only.
	spu_regfile #(
		.AW    (8),
		.DEPTH (256)
	) u_regfile (
		.core_clk_i (core_clk_i),
		.we_i       (rf_we),
		.waddr_i    (work_ptr[7:0]),
		.wdata_i    (push_buf[byte_idx]),
		.raddr_i    (work_ptr[7:0]),
		.rdata_o    (rf_rdata)
	);

	// ==========================================================
	// Sequencer: one byte per pass, pointer moves around each byte.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			state     <= spu_pkg::ST_IDLE;
			work_ptr  <= 16'h0000;
			byte_cnt  <= 2'h0;
			byte_idx  <= 2'h0;
			is_pop    <= 1'b0;
			is_user   <= 1'b0;
			use_ext   <= 1'b0;
			step_down <= 1'b0;
			cur_op    <= spu_pkg::OP_PUSH;
			pop_shift <= 24'h000000;
			push_buf  <= '{8'h00, 8'h00, 8'h00};
		end
		else
		begin
			unique case (state)
				spu_pkg::ST_IDLE:
				begin
					if (op_start)
					begin
						cur_op   <= op_code_i;
						is_pop   <= pop_op;
						is_user  <= user_op;
						byte_idx <= 2'h0;
						pop_shift <= 24'h000000;
						if (user_op)
						begin
							// op_down_i picks the growth direction; pops step the other way.
							work_ptr  <= usr_ptr_i;
							use_ext   <= op_ext_i;
							step_down <= (op_code_i == spu_pkg::OP_UPUSH) ?
								op_down_i : ~op_down_i;
						end
						else
						begin
							work_ptr  <= {stack_pointer_high,
								stack_pointer_low};
							use_ext   <= ~stack_internal;
							step_down <= ~pop_op;
						end
						// Push order: PC low, PC high, then flags on top.
						unique case (op_code_i)
							spu_pkg::OP_CALL, spu_pkg::OP_RET:
							begin
								byte_cnt <= spu_pkg::BYTES_PC;
								push_buf <= '{pc_i[7:0], pc_i[15:8], 8'h00};
							end
							spu_pkg::OP_INT, spu_pkg::OP_INTERRUPT_RETURN:
							begin
								byte_cnt <= spu_pkg::BYTES_FRAME;
								push_buf <= '{pc_i[7:0], pc_i[15:8], flags_i};
							end
							default:
							begin
								byte_cnt <= spu_pkg::BYTES_ONE;
								push_buf <= '{push_data_i, 8'h00, 8'h00};
							end
						endcase
						state <= pop_op ? spu_pkg::ST_POP_GET :
							spu_pkg::ST_PUSH_STEP;
					end
				end
				spu_pkg::ST_PUSH_STEP:
				begin
					// Full 16-bit step lets an internal wrap reach high.
					work_ptr <= spu_pkg::spu_step(work_ptr, step_down);
					state    <= spu_pkg::ST_PUSH_PUT;
				end
				spu_pkg::ST_PUSH_PUT:
				begin
					// Write lands at the freshly moved pointer.
					if (use_ext)
						state <= spu_pkg::ST_EXT_WAIT;
					else if (last_byte)
						state <= spu_pkg::ST_DONE;
					else
					begin
						byte_idx <= byte_idx + 2'h1;
						state    <= spu_pkg::ST_PUSH_STEP;
					end
				end
				spu_pkg::ST_POP_GET:
				begin
					state <= use_ext ? spu_pkg::ST_EXT_WAIT :
						spu_pkg::ST_POP_CATCH;
				end
				spu_pkg::ST_POP_CATCH:
				begin
					// Data taken first, pointer moves afterwards.
					pop_shift <= {pop_shift[15:0], rf_rdata};
					work_ptr  <= spu_pkg::spu_step(work_ptr, step_down);
					byte_idx  <= byte_idx + 2'h1;
					state     <= last_byte ? spu_pkg::ST_DONE :
						spu_pkg::ST_POP_GET;
				end
				spu_pkg::ST_EXT_WAIT:
				begin
					// External memory may stretch the access with its ack.
					if (ext_ack_i)
					begin
						byte_idx <= byte_idx + 2'h1;
						if (is_pop)
						begin
							pop_shift <= {pop_shift[15:0], ext_rdata_i};
							work_ptr  <= spu_pkg::spu_step(work_ptr,
								step_down);
							state <= last_byte ? spu_pkg::ST_DONE :
								spu_pkg::ST_POP_GET;
						end
						else
							state <= last_byte ? spu_pkg::ST_DONE :
								spu_pkg::ST_PUSH_STEP;
					end
				end
				spu_pkg::ST_DONE:
					state <= spu_pkg::ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// External memory strobes, held until the memory acknowledges.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			ext_addr_o  <= 16'h0000;
			ext_wdata_o <= 8'h00;
			ext_wr_o    <= 1'b0;
			ext_rd_o    <= 1'b0;
		end
		else if ((state == spu_pkg::ST_EXT_WAIT) && ext_ack_i)
		begin
			ext_wr_o <= 1'b0;
			ext_rd_o <= 1'b0;
		end
		else if (use_ext && (state == spu_pkg::ST_PUSH_PUT))
		begin
			ext_addr_o  <= work_ptr;
			ext_wdata_o <= push_buf[byte_idx];
			ext_wr_o    <= 1'b1;
		end
		else if (use_ext && (state == spu_pkg::ST_POP_GET))
		begin
			ext_addr_o <= work_ptr;
			ext_rd_o   <= 1'b1;
		end
	end

	// ==========================================================
	// Pointer pair and timing control: sequencer commit, APB writes.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			stack_pointer_high    <= spu_pkg::SP_HIGH_RST;
			stack_pointer_low     <= spu_pkg::SP_LOW_RST;
			memory_timing_control <= spu_pkg::MEM_TIME_RST;
		end
		else if ((state == spu_pkg::ST_DONE) && !is_user)
		begin
			// Internal mode still commits the high byte, so a wrap of
			// the low byte shows up in it.
			stack_pointer_high <= work_ptr[15:8];
			stack_pointer_low  <= work_ptr[7:0];
		end
		else if (apb_commit && pwrite_i)
		begin
			// High byte stays a plain register for software.
			if (paddr_i == spu_pkg::ADDR_SP_HIGH)
				stack_pointer_high <= pwdata_i[7:0];
			if (paddr_i == spu_pkg::ADDR_SP_LOW)
				stack_pointer_low <= pwdata_i[7:0];
			if (paddr_i == spu_pkg::ADDR_MEM_TIME)
				memory_timing_control <= pwdata_i[7:0];
		end
	end

	// ==========================================================
	// APB answer: one wait state, data and error with pready.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end
		else
		begin
			pready_o  <= apb_access;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
			if (apb_access)
			begin
				unique case (paddr_i)
					spu_pkg::ADDR_SP_HIGH:
						prdata_o <= {24'h000000, stack_pointer_high};
					spu_pkg::ADDR_SP_LOW:
						prdata_o <= {24'h000000, stack_pointer_low};
					spu_pkg::ADDR_MEM_TIME:
						prdata_o <= {24'h000000, memory_timing_control};
					spu_pkg::ADDR_STATUS:
					begin
						prdata_o[spu_pkg::STS_BUSY_BIT] <=
							(state != spu_pkg::ST_IDLE);
						prdata_o[spu_pkg::STS_INT_BIT] <= stack_internal;
					end
					default:
						pslverr_o <= 1'b1;
				endcase
			end
		end
	end

	// ==========================================================
	// Answers to the sequencer, presented with a one-cycle done pulse.
	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			op_busy_o  <= 1'b0;
			op_done_o  <= 1'b0;
			pop_data_o <= 8'h00;
			pc_o       <= 16'h0000;
			flags_o    <= 8'h00;
			usr_ptr_o  <= 16'h0000;
		end
		else
		begin
			op_done_o <= (state == spu_pkg::ST_DONE);
			if (op_start)
				op_busy_o <= 1'b1;
			else if (state == spu_pkg::ST_DONE)
				op_busy_o <= 1'b0;
			if (state == spu_pkg::ST_DONE)
			begin
				if (is_user)
					usr_ptr_o <= work_ptr;
				if (cur_op == spu_pkg::OP_RET)
					pc_o <= pop_shift[15:0];
				if (cur_op == spu_pkg::OP_INTERRUPT_RETURN)
				begin
					// Flags came off first, then PC high, then PC low.
					flags_o <= pop_shift[23:16];
					pc_o    <= pop_shift[15:0];
				end
				if ((cur_op == spu_pkg::OP_POP) ||
					(cur_op == spu_pkg::OP_UPOP))
					pop_data_o <= pop_shift[7:0];
			end
		end
	end

endmodule : spu_core

// ===== src/spu_pkg.sv
// Package with the map, op codes, states and helpers of the stack pointer unit.
package spu_pkg;

	// ==========================================================
	// Register map: printed indices, byte address is four times.
	localparam logic [9:0]  IDX_SP_HIGH  = 10'h0D8;
	localparam logic [9:0]  IDX_SP_LOW   = 10'h0D9;
	localparam logic [9:0]  IDX_MEM_TIME = 10'h0FE;
	localparam logic [9:0]  IDX_STATUS   = 10'h000;
	localparam logic [11:0] ADDR_SP_HIGH  = {IDX_SP_HIGH, 2'b00};
	localparam logic [11:0] ADDR_SP_LOW   = {IDX_SP_LOW, 2'b00};
	localparam logic [11:0] ADDR_MEM_TIME = {IDX_MEM_TIME, 2'b00};
	localparam logic [11:0] ADDR_STATUS   = {IDX_STATUS, 2'b00};

	// ==========================================================
	// Field positions and reset values.
	localparam int         MTC_STACK_INT_BIT = 1;
	localparam int         STS_BUSY_BIT      = 0;
	localparam int         STS_INT_BIT       = 1;
	localparam logic [7:0] SP_HIGH_RST       = 8'h00;
	localparam logic [7:0] SP_LOW_RST        = 8'h00;
	localparam logic [7:0] MEM_TIME_RST      = 8'h00;

	// ==========================================================
	// Stack operation codes issued by the sequencer.
	localparam logic [2:0] OP_PUSH  = 3'h0;
	localparam logic [2:0] OP_POP   = 3'h1;
	localparam logic [2:0] OP_CALL  = 3'h2;
	localparam logic [2:0] OP_RET   = 3'h3;
	localparam logic [2:0] OP_INT   = 3'h4;
	localparam logic [2:0] OP_INTERRUPT_RETURN  = 3'h5;
	localparam logic [2:0] OP_UPUSH = 3'h6;
	localparam logic [2:0] OP_UPOP  = 3'h7;

	// Bytes moved by each kind of operation.
	localparam logic [1:0] BYTES_ONE   = 2'h1;
	localparam logic [1:0] BYTES_PC    = 2'h2;
	localparam logic [1:0] BYTES_FRAME = 2'h3;

	// ==========================================================
	// Sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PUSH_STEP,
		ST_PUSH_PUT,
		ST_POP_GET,
		ST_POP_CATCH,
		ST_EXT_WAIT,
		ST_DONE
	} spu_state_type;

	// One pointer step; the full pair always moves so carries reach high.
	function automatic logic [15:0] spu_step(input logic [15:0] ptr,
		input logic down);
		if (down)
			spu_step = ptr - 16'h0001;
		else
			spu_step = ptr + 16'h0001;
	endfunction : spu_step

endpackage : spu_pkg

// ===== src/spu_regfile.sv
// Byte-wide register file that holds the internal stack.
`timescale 1ns/10ps
module spu_regfile #(
	parameter int AW    = 8,
	parameter int DEPTH = 256
) (
	// Clock.
	input  wire logic          core_clk_i,
	// Write port.
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [7:0]    wdata_i,
	// Read port, data one cycle after the address.
	input  wire logic [AW-1:0] raddr_i,
	output logic      [7:0]    rdata_o
);

	// ==========================================================
	// Elaboration check.
	if (DEPTH != (1 << AW))
	begin : g_bad_depth
		$error("spu_regfile: DEPTH must equal two to the power AW.");
	end

	logic [7:0] mem [DEPTH];

	// Contents need no reset; software sets up the stack before use.
	always_ff @(posedge core_clk_i)
	begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
	end

	// Registered read keeps the output straight off a flip-flop.
	always_ff @(posedge core_clk_i)
	begin
		rdata_o <= mem[raddr_i];
	end

endmodule : spu_regfile

// ===== sim/spu_mem_model.sv
// External data memory model facing the unit's memory port.
`timescale 1ns/10ps
module spu_mem_model (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Memory port.
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        slow_i,
	output logic      [7:0]  rdata_o,
	output logic             ack_o
);
	logic [7:0] mem [0:65535];
	logic [1:0] wait_cnt;

	// Each strobe gets one acknowledge, three cycles later when slow.
	// Read data toggles outside the acknowledge so a late sample fails.
	always_ff @(posedge clk_i)
		if (!resetn_i)
		begin
			ack_o <= 1'b0;
			wait_cnt <= 2'h0;
			rdata_o <= 8'h00;
		end
		else if ((wr_i || rd_i) && !ack_o
			&& wait_cnt == (slow_i ? 2'h3 : 2'h0))
		begin
			ack_o <= 1'b1;
			wait_cnt <= 2'h0;
			rdata_o <= mem[addr_i];
			if (wr_i)
				mem[addr_i] <= wdata_i;
		end
		else
		begin
			ack_o <= 1'b0;
			rdata_o <= ~rdata_o;
			if ((wr_i || rd_i) && !ack_o)
				wait_cnt <= wait_cnt + 2'h1;
		end
endmodule : spu_mem_model

// ===== sim/spu_core_chk.sv
// Port timing checker of the stack pointer unit.
`timescale 1ns/10ps
module spu_core_chk (
	// Clock and reset.
	input wire logic        core_clk_i,
	input wire logic        resetn_i,
	// APB.
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	// Stack operations and memory port.
	input wire logic [2:0]  op_code_i,
	input wire logic        op_busy_o,
	input wire logic        op_done_o,
	input wire logic [15:0] ext_addr_o,
	input wire logic [7:0]  ext_wdata_o,
	input wire logic        ext_wr_o,
	input wire logic        ext_rd_o,
	input wire logic        ext_ack_i
);
	logic int_mode;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// Shadow of the stack location bit, so timing can depend on the path.
	always_ff @(posedge core_clk_i)
		if (!resetn_i)
			int_mode <= 1'b0;
		else if (psel_i && penable_i && pready_o && pwrite_i
			&& paddr_i == spu_pkg::ADDR_MEM_TIME)
			int_mode <= pwdata_i[spu_pkg::MTC_STACK_INT_BIT];

	// ==========================================================
	// Assertions.
	a_apb_wait:
		assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("APB answer not one cycle after access start");
	a_ready_pulse:
		assert property (pready_o |=> !pready_o)
		else $error("APB ready longer than one cycle");
	a_err_ready:
		assert property (pslverr_o |-> pready_o && psel_i && penable_i)
		else $error("APB error outside an answer");
	a_done_ends_busy:
		assert property (op_done_o |-> !op_busy_o && $past(op_busy_o))
		else $error("Done without a preceding busy period");
	a_push_time:
		assert property ($rose(op_busy_o) && int_mode
			&& op_code_i == spu_pkg::OP_PUSH |-> ##3 op_done_o)
		else $error("Internal push not done in time");
	a_int_no_mem:
		assert property (int_mode && op_code_i != spu_pkg::OP_UPUSH
			&& op_code_i != spu_pkg::OP_UPOP |-> !ext_wr_o && !ext_rd_o)
		else $error("Memory strobe with internal stack");
	a_wr_hold:
		assert property (ext_wr_o && !ext_ack_i |=> ext_wr_o
			&& $stable(ext_addr_o) && $stable(ext_wdata_o))
		else $error("Memory write changed before acknowledge");
	a_strobe_drop:
		assert property ((ext_wr_o || ext_rd_o) && ext_ack_i
			|=> !ext_wr_o && !ext_rd_o)
		else $error("Memory strobe held after acknowledge");
	a_strobe_busy:
		assert property (ext_wr_o || ext_rd_o |-> op_busy_o
			&& !(ext_wr_o && ext_rd_o))
		else $error("Memory strobe outside a single operation");
endmodule : spu_core_chk

bind spu_core spu_core_chk u_chk (
	.core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.op_code_i(op_code_i), .op_busy_o(op_busy_o),
	.op_done_o(op_done_o), .ext_addr_o(ext_addr_o),
	.ext_wdata_o(ext_wdata_o), .ext_wr_o(ext_wr_o),
	.ext_rd_o(ext_rd_o), .ext_ack_i(ext_ack_i));

// ===== sim/tb_spu_core.sv
// Self-checking bench of the stack pointer unit.
`timescale 1ns/10ps
module tb_spu_core;
	localparam logic [11:0] AH = spu_pkg::ADDR_SP_HIGH;
	localparam logic [11:0] AL = spu_pkg::ADDR_SP_LOW;
	localparam logic [11:0] AT = spu_pkg::ADDR_MEM_TIME;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic        ov = 1'b0;
	logic        odn = 1'b0;
	logic        oext = 1'b0;
	logic        slow = 1'b0;
	logic [2:0]  oc = 3'h0;
	logic [15:0] v16 = 16'h0;
	logic [7:0]  v8 = 8'h0;
	logic [31:0] prd, rdat;
	logic        prdy, perr, rerr, busy, done, ewr, erd, eack;
	logic [15:0] pco, uptro, eadr;
	logic [7:0]  popd, flgo, ewd, erdat;
	int          err_count = 0;
	int          check_count = 0;

	// Clock of 4 ns.
	always #2 clk = ~clk;

	spu_core u_dut (
		.core_clk_i(clk), .resetn_i(rstn), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
		.pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
		.pslverr_o(perr), .op_valid_i(ov), .op_code_i(oc),
		.op_down_i(odn), .op_ext_i(oext), .usr_ptr_i(v16),
		.push_data_i(v8), .pc_i(v16), .flags_i(v8),
		.op_busy_o(busy), .op_done_o(done), .pop_data_o(popd),
		.pc_o(pco), .flags_o(flgo), .usr_ptr_o(uptro),
		.ext_addr_o(eadr), .ext_wdata_o(ewd), .ext_wr_o(ewr),
		.ext_rd_o(erd), .ext_rdata_i(erdat), .ext_ack_i(eack));
	spu_mem_model u_mem (
		.clk_i(clk), .resetn_i(rstn), .addr_i(eadr), .wdata_i(ewd),
		.wr_i(ewr), .rd_i(erd), .slow_i(slow), .rdata_o(erdat),
		.ack_o(eack));

	// ==========================================================
	// Checking and closing.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask : chk

	// ==========================================================
	// Bus and operation tasks; waits are bounded.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		// Ready is sampled at the rising edge; data is taken there too.
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (prdy !== 1'b1 && n < 20);
		rdat = prd;
		rerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (prdy !== 1'b1)
		begin
			err_count++;
			end_sim();
		end
	endtask : apb

	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(rdat, {24'h0, e});
	endtask : rc

	task automatic sp(input logic [15:0] v);
		apb(1'b1, AH, v[15:8]);
		apb(1'b1, AL, v[7:0]);
	endtask : sp

	task automatic csp(input logic [15:0] v);
		rc(AH, v[15:8]);
		rc(AL, v[7:0]);
	endtask : csp

	task automatic cm(input logic [15:0] a, input logic [7:0] e);
		chk({24'h0, u_mem.mem[a]}, {24'h0, e});
	endtask : cm

	task automatic op(input logic [2:0] c, input logic dn,
		input logic ex, input logic [15:0] w, input logic [7:0] b);
		int n;
		@(posedge clk);
		ov <= 1'b1;
		oc <= c;
		odn <= dn;
		oext <= ex;
		v16 <= w;
		v8 <= b;
		// Request stands until busy is sampled high at a rising edge.
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (busy !== 1'b1 && n < 20);
		ov <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (done !== 1'b1 && n < 40);
		if (done !== 1'b1)
		begin
			err_count++;
			end_sim();
		end
	endtask : op

	// ==========================================================
	// Test sequence.
	initial
	begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		csp({spu_pkg::SP_HIGH_RST, spu_pkg::SP_LOW_RST});
		rc(AT, spu_pkg::MEM_TIME_RST);
		rc(12'h004, 8'h00);
		chk({31'h0, rerr}, 32'h1);
		$display("test reset done");
		// Internal stack; the low byte wraps into the high byte.
		apb(1'b1, AT, 8'h02);
		rc(12'h000, 8'h02);
		sp(16'h0100);
		op(spu_pkg::OP_PUSH, 1'b0, 1'b0, 16'h0, 8'hA5);
		csp(16'h00FF);
		op(spu_pkg::OP_POP, 1'b0, 1'b0, 16'h0, 8'h00);
		chk({24'h0, popd}, 32'hA5);
		csp(16'h0100);
		op(spu_pkg::OP_CALL, 1'b0, 1'b0, 16'h1234, 8'h00);
		csp(16'h00FE);
		op(spu_pkg::OP_RET, 1'b0, 1'b0, 16'h0, 8'h00);
		chk({16'h0, pco}, 32'h1234);
		op(spu_pkg::OP_INT, 1'b0, 1'b0, 16'hBEEF, 8'h5A);
		csp(16'h00FD);
		op(spu_pkg::OP_INTERRUPT_RETURN, 1'b0, 1'b0, 16'h0, 8'h00);
		chk({8'h0, pco, flgo}, 32'hBEEF5A);
		sp(16'h3710);
		op(spu_pkg::OP_PUSH, 1'b0, 1'b0, 16'h0, 8'h11);
		csp(16'h370F);
		// Software reuses the high byte; the internal stack ignores it.
		apb(1'b1, AH, 8'h55);
		op(spu_pkg::OP_POP, 1'b0, 1'b0, 16'h0, 8'h00);
		chk({24'h0, popd}, 32'h11);
		csp(16'h5510);
		$display("test internal stack done");
		// External stack behind a slow memory.
		apb(1'b1, AT, 8'h00);
		slow <= 1'b1;
		sp(16'h2000);
		op(spu_pkg::OP_INT, 1'b0, 1'b0, 16'hC3A1, 8'h96);
		cm(16'h1FFF, 8'hA1);
		cm(16'h1FFE, 8'hC3);
		cm(16'h1FFD, 8'h96);
		csp(16'h1FFD);
		op(spu_pkg::OP_INTERRUPT_RETURN, 1'b0, 1'b0, 16'h0, 8'h00);
		chk({8'h0, pco, flgo}, 32'hC3A196);
		csp(16'h2000);
		$display("test external stack done");
		// User stacks in both directions and both places.
		op(spu_pkg::OP_UPUSH, 1'b1, 1'b0, 16'h0050, 8'h66);
		chk({16'h0, uptro}, 32'h004F);
		op(spu_pkg::OP_UPOP, 1'b1, 1'b0, 16'h004F, 8'h00);
		chk({8'h0, popd, uptro}, 32'h660050);
		op(spu_pkg::OP_UPUSH, 1'b0, 1'b1, 16'h3000, 8'h77);
		cm(16'h3001, 8'h77);
		op(spu_pkg::OP_UPOP, 1'b0, 1'b1, 16'h3001, 8'h00);
		chk({8'h0, popd, uptro}, 32'h773000);
		$display("test user stacks done");
		end_sim();
	end
endmodule : tb_spu_core
